// *** dsg_pkg.sv ***
// Purpose: Constants and types for deep-sleep port gating and soft reset
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: Register offsets are byte addresses
package dsg_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NUM_PORTS = 5;

   // Register byte offsets
   localparam logic [11:0] OFF_SOFT_RESET_0 = 12'h040;
   localparam logic [11:0] OFF_DEEP_GATE_2 = 12'h128;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h200;
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h204;
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h208;

   // Field positions
   localparam int WDOG_RST_BIT = 3;
   localparam int PORT_A_BIT = 0;
   localparam int PORT_E_BIT = 4;

   // Reset values
   localparam logic [4:0] DEEP_GATE_RST = 5'h00;
   localparam logic WDOG_RST_RST = 1'b0;
   localparam logic [4:0] IRQ_RST = 5'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Avalon response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power mode and gating select, driven by the power controller
   typedef struct packed {
      logic auto_sleep_gating_bit;
      logic sleep;
      logic deep_sleep;
   } dsg_mode_t;

   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_RESP
   } dsg_bus_st_t;

endpackage : dsg_pkg

// *** dsg_gate_cell.sv ***
// Purpose: Clock gate select and access fault for one port
// Assumes: Access requests come from logic on clk
// Notes: Enable is registered, so a change shows one cycle after its cause
`timescale 1ns/1ps
module dsg_gate_cell
   import dsg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Gate sources
   input wire logic run_en,
   input wire logic sleep_en,
   input wire logic deep_en,
   input wire dsg_mode_t mode,
   // Port access
   input wire logic access_req,
   output logic clk_en_r,
   output logic fault_r
);

   logic clk_en_nxt;

   always_comb begin
      clk_en_nxt = run_en;
      if (mode.auto_sleep_gating_bit) begin
         if (mode.deep_sleep) begin
            clk_en_nxt = deep_en;
         end else if (mode.sleep) begin
            clk_en_nxt = sleep_en;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         clk_en_r <= 1'b0;
      end else begin
         clk_en_r <= clk_en_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_r <= 1'b0;
      end else begin
         fault_r <= access_req && !clk_en_r;
      end
   end

   property p_fault_gated;
      @(posedge clk) disable iff (reset)
      access_req && !clk_en_r |=> fault_r;
   endproperty
   a_fault_gated: assert property (p_fault_gated) else $error("no fault on gated access");

   property p_no_fault_clocked;
      @(posedge clk) disable iff (reset)
      access_req && clk_en_r |=> !fault_r;
   endproperty
   a_no_fault_clocked: assert property (p_no_fault_clocked) else $error("fault on clocked port");

   property p_deep_source;
      @(posedge clk) disable iff (reset)
      mode.auto_sleep_gating_bit && mode.deep_sleep |=> clk_en_r == $past(deep_en);
   endproperty
   a_deep_source: assert property (p_deep_source) else $error("deep sleep gate not used");

   property p_run_without_auto;
      @(posedge clk) disable iff (reset)
      !mode.auto_sleep_gating_bit |=> clk_en_r == $past(run_en);
   endproperty
   a_run_without_auto: assert property (p_run_without_auto) else $error("run gate ignored");

endmodule : dsg_gate_cell

// *** dsg_clock_reset_ctl.sv ***
// Purpose: Deep-sleep port clock gates and watchdog soft reset registers
// Assumes: Mode, run and sleep gates, capability and accesses come from clk logic
// Notes: Every register access takes one wait cycle; unmapped offsets give SLVERR
`timescale 1ns/1ps
// Function
// - A set gate bit clocks its port; a clear bit leaves it unclocked.
// - Any access to a gated-off port raises a bus fault.
// - All gate bits are zero after reset, so ports start unclocked.
// - Run, sleep or deep-sleep gates apply according to the power mode.
// - Sleep and deep-sleep gates apply only with automatic gating set.
// - Deep-sleep gate bits for ports E to A sit at bits 4 to 0.
// - Reserved bits read zero; software keeps them on read-modify-write.
// - Soft reset writes are masked by the capability bits.
// - Bit 3 of the soft reset register is the watchdog reset control.
module dsg_clock_reset_ctl
   import dsg_pkg::*;
#(
   parameter int NPORT = NUM_PORTS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // Gating sources from the rest of the clock controller
   input wire logic [NPORT-1:0] run_port_gate_reg,
   input wire logic [NPORT-1:0] sleep_port_gate_reg,
   input wire dsg_mode_t mode,
   // Capability mask for the soft reset register
   input wire logic [DATA_W-1:0] capability_reg_one,
   // Port side
   input wire logic [NPORT-1:0] port_access_req,
   output logic [NPORT-1:0] port_clk_en,
   output logic [NPORT-1:0] port_bus_fault,
   // Watchdog and interrupt
   output logic watchdog_reset_ctl,
   output logic irq
);

   dsg_bus_st_t bus_st_r;
   logic [NPORT-1:0] deep_port_gate_reg_r;
   logic wdog_rst_r;
   logic [NPORT-1:0] irq_status_r;
   logic [NPORT-1:0] irq_enable_r;
   logic irq_r;
   logic waitreq_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] resp_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [1:0] resp_nxt;
   logic [NPORT-1:0] status_nxt;
   logic wdog_rst_nxt;
   logic req;
   logic req_take;
   logic wr_done;
   logic hit_deep;
   logic hit_srst;
   logic hit_stat;
   logic hit_clr;
   logic hit_en;
   logic [NPORT-1:0] clr_bits;

   assign req = avs_read || avs_write;
   assign req_take = (bus_st_r == BUS_IDLE) && req;
   assign wr_done = (bus_st_r == BUS_RESP) && avs_write;
   assign hit_deep = avs_address == OFF_DEEP_GATE_2;
   assign hit_srst = avs_address == OFF_SOFT_RESET_0;
   assign hit_stat = avs_address == OFF_IRQ_STATUS;
   assign hit_clr = avs_address == OFF_IRQ_CLEAR;
   assign hit_en = avs_address == OFF_IRQ_ENABLE;

   // Bus slave: request seen in idle, answered with waitrequest low next cycle.
   // The fixed single wait keeps read data registered without a combinational path.
   always_ff @(posedge clk) begin
      if (reset) begin
         bus_st_r <= BUS_IDLE;
         waitreq_r <= 1'b1;
      end else begin
         case (bus_st_r)
            BUS_IDLE: begin
               if (req) begin
                  bus_st_r <= BUS_RESP;
                  waitreq_r <= 1'b0;
               end
            end
            BUS_RESP: begin
               bus_st_r <= BUS_IDLE;
               waitreq_r <= 1'b1;
            end
            default: begin
               bus_st_r <= BUS_IDLE;
               waitreq_r <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      rdata_nxt = RDATA_RST;
      resp_nxt = RESP_OKAY;
      if (hit_deep) begin
         rdata_nxt[NPORT-1:0] = deep_port_gate_reg_r;
      end else if (hit_srst) begin
         rdata_nxt[WDOG_RST_BIT] = wdog_rst_r;
      end else if (hit_stat) begin
         rdata_nxt[NPORT-1:0] = irq_status_r;
      end else if (hit_en) begin
         rdata_nxt[NPORT-1:0] = irq_enable_r;
      end else if (!hit_clr) begin
         resp_nxt = RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= RDATA_RST;
         resp_r <= RESP_OKAY;
      end else if (req_take) begin
         rdata_r <= avs_read ? rdata_nxt : RDATA_RST;
         resp_r <= resp_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         deep_port_gate_reg_r <= DEEP_GATE_RST;
      end else if (wr_done && hit_deep) begin
         deep_port_gate_reg_r <= avs_writedata[NPORT-1:0];
      end
   end

   always_comb begin
      wdog_rst_nxt = wdog_rst_r;
      if (capability_reg_one[WDOG_RST_BIT]) begin
         wdog_rst_nxt = avs_writedata[WDOG_RST_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wdog_rst_r <= WDOG_RST_RST;
      end else if (wr_done && hit_srst) begin
         wdog_rst_r <= wdog_rst_nxt;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_port
         dsg_gate_cell u_cell (
            .clk(clk),
            .reset(reset),
            .run_en(run_port_gate_reg[gi]),
            .sleep_en(sleep_port_gate_reg[gi]),
            .deep_en(deep_port_gate_reg_r[gi]),
            .mode(mode),
            .access_req(port_access_req[gi]),
            .clk_en_r(port_clk_en[gi]),
            .fault_r(port_bus_fault[gi])
         );
      end
   endgenerate

   // A fault pulse in the clearing cycle survives: set wins over clear
   assign clr_bits = (wr_done && hit_clr) ? avs_writedata[NPORT-1:0] : IRQ_RST;
   assign status_nxt = (irq_status_r & ~clr_bits) | port_bus_fault;

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_status_r <= IRQ_RST;
      end else begin
         irq_status_r <= status_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_enable_r <= IRQ_RST;
      end else if (wr_done && hit_en) begin
         irq_enable_r <= avs_writedata[NPORT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_status_r & irq_enable_r);
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = waitreq_r;
   assign avs_response = resp_r;
   assign watchdog_reset_ctl = wdog_rst_r;
   assign irq = irq_r;

   property p_gates_cleared;
      @(posedge clk)
      reset |=> deep_port_gate_reg_r == DEEP_GATE_RST && port_clk_en == '0;
   endproperty
   a_gates_cleared: assert property (p_gates_cleared) else $error("gates not cleared by reset");

   property p_one_wait;
      @(posedge clk) disable iff (reset)
      req_take |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");

   property p_deep_write;
      @(posedge clk) disable iff (reset)
      wr_done && hit_deep |=> deep_port_gate_reg_r == $past(avs_writedata[NPORT-1:0]);
   endproperty
   a_deep_write: assert property (p_deep_write) else $error("deep gate write lost");

   property p_deep_read;
      @(posedge clk) disable iff (reset)
      req_take && avs_read && hit_deep |=> avs_readdata[NPORT-1:0] == $past(deep_port_gate_reg_r);
   endproperty
   a_deep_read: assert property (p_deep_read) else $error("deep gate readback wrong");

   property p_reserved_zero;
      @(posedge clk) disable iff (reset)
      !avs_waitrequest |-> avs_readdata[DATA_W-1:NPORT] == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

   property p_wdog_masked;
      @(posedge clk) disable iff (reset)
      wr_done && hit_srst && !capability_reg_one[WDOG_RST_BIT] |=> $stable(watchdog_reset_ctl);
   endproperty
   a_wdog_masked: assert property (p_wdog_masked) else $error("masked write changed reset");

   property p_wdog_set;
      @(posedge clk) disable iff (reset)
      wr_done && hit_srst && capability_reg_one[WDOG_RST_BIT] |=>
         watchdog_reset_ctl == $past(avs_writedata[WDOG_RST_BIT]);
   endproperty
   a_wdog_set: assert property (p_wdog_set) else $error("watchdog reset bit not written");

   property p_wdog_read;
      @(posedge clk) disable iff (reset)
      req_take && avs_read && hit_srst |=> avs_readdata[WDOG_RST_BIT] == $past(wdog_rst_r);
   endproperty
   a_wdog_read: assert property (p_wdog_read) else $error("watchdog bit readback wrong");

   property p_fault_sticky;
      @(posedge clk) disable iff (reset)
      |port_bus_fault |=> (irq_status_r & $past(port_bus_fault)) == $past(port_bus_fault);
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault event lost");

   property p_irq_level;
      @(posedge clk) disable iff (reset)
      ##1 irq == |($past(irq_status_r) & $past(irq_enable_r));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   property p_srst_reserved;
      @(posedge clk) disable iff (reset)
      req_take && avs_read && hit_srst |=>
         avs_readdata[DATA_W-1:WDOG_RST_BIT+1] == '0 && avs_readdata[WDOG_RST_BIT-1:0] == '0;
   endproperty
   a_srst_reserved: assert property (p_srst_reserved) else $error("reserved bit set");

   property p_deep_hold;
      @(posedge clk) disable iff (reset)
      !(wr_done && hit_deep) |=> $stable(deep_port_gate_reg_r);
   endproperty
   a_deep_hold: assert property (p_deep_hold) else $error("deep gate drifted");

   property p_wdog_hold;
      @(posedge clk) disable iff (reset)
      !(wr_done && hit_srst) |=> $stable(watchdog_reset_ctl);
   endproperty
   a_wdog_hold: assert property (p_wdog_hold) else $error("watchdog bit drifted");

   property p_mapped_ok;
      @(posedge clk) disable iff (reset)
      req_take && (hit_srst || hit_deep) |=> avs_response == RESP_OKAY;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");

   property p_unmapped_err;
      @(posedge clk) disable iff (reset)
      req_take && !hit_deep && !hit_srst && !hit_stat && !hit_clr && !hit_en |=>
         avs_response == RESP_SLVERR;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access accepted");

   property p_status_clear;
      @(posedge clk) disable iff (reset)
      wr_done && hit_clr && !(|port_bus_fault) |=>
         (irq_status_r & $past(avs_writedata[NPORT-1:0])) == '0;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");

   property p_status_kept;
      @(posedge clk) disable iff (reset)
      !(wr_done && hit_clr) |=>
         (irq_status_r & $past(irq_status_r)) == $past(irq_status_r);
   endproperty
   a_status_kept: assert property (p_status_kept) else $error("status bit lost");

   property p_status_cause;
      @(posedge clk) disable iff (reset)
      1'b1 |=> (irq_status_r & ~$past(irq_status_r) & ~$past(port_bus_fault)) == '0;
   endproperty
   a_status_cause: assert property (p_status_cause) else $error("status set without fault");

   property p_run_select;
      @(posedge clk) disable iff (reset)
      !mode.auto_sleep_gating_bit |=> port_clk_en == $past(run_port_gate_reg);
   endproperty
   a_run_select: assert property (p_run_select) else $error("run gates not applied");

   property p_sleep_select;
      @(posedge clk) disable iff (reset)
      mode.auto_sleep_gating_bit && mode.sleep && !mode.deep_sleep |=>
         port_clk_en == $past(sleep_port_gate_reg);
   endproperty
   a_sleep_select: assert property (p_sleep_select) else $error("sleep gates not applied");

   property p_wait_idle;
      @(posedge clk) disable iff (reset)
      avs_waitrequest && !req |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("answer without request");

endmodule : dsg_clock_reset_ctl

// *** dsg_bus_master.sv ***
// Purpose: Processor-side Avalon-MM master model for the gating registers
// Assumes: One request at a time, started by a one-cycle start pulse
// Notes: Address and data are inverted when idle so stale values never match
`timescale 1ns/1ps
module dsg_bus_master
   import dsg_pkg::*;
(
   // Clock
   input wire logic clk,
   // Command side
   input wire logic start,
   input wire logic wr,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   output logic done = 1'b0,
   output logic [DATA_W-1:0] rdata = '0,
   output logic [1:0] resp = 2'h0,
   // Avalon-MM master
   output logic [ADDR_W-1:0] avs_address = '0,
   output logic avs_read = 1'b0,
   output logic avs_write = 1'b0,
   output logic [DATA_W-1:0] avs_writedata = '0,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response
);
   logic busy = 1'b0;
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (busy && !avs_waitrequest) begin
         busy <= 1'b0;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         avs_address <= ~avs_address;
         avs_writedata <= ~avs_writedata;
         rdata <= avs_readdata;
         resp <= avs_response;
         done <= 1'b1;
      end else if (start && !busy) begin
         busy <= 1'b1;
         avs_read <= !wr;
         avs_write <= wr;
         avs_address <= addr;
         avs_writedata <= wdata;
      end
   end
endmodule : dsg_bus_master

// *** test_dsg_clock_reset_ctl.sv ***
// Purpose: Self-checking bench for port gating, soft reset and fault interrupt
// Assumes: Registers reached through the bus master model
// Notes: Gating cases run from a table; reset and faults are written out
`timescale 1ns/1ps
module test_dsg_clock_reset_ctl
   import dsg_pkg::*;
;
   typedef struct packed {
      dsg_mode_t m;
      logic [4:0] run;
      logic [4:0] slp;
      logic [4:0] deep;
      logic [4:0] exp;
   } dsg_row_t;
   logic clk = 1'b0, reset = 1'b1, start = 1'b0, wr = 1'b0, done, irq, wdog;
   logic [ADDR_W-1:0] addr = '0, av_a;
   logic [DATA_W-1:0] wdata = '0, rdata, av_wd, av_rd, cap = 32'h0000_0008;
   logic [1:0] resp, av_resp;
   logic av_r, av_w, av_wait;
   logic [4:0] run = '0, slp = '0, req = '0, clk_en, fault;
   dsg_mode_t mode = '0;
   int n_errors = 0, num_checks = 0, cyc = 0;
   dsg_row_t rows [6] = '{
      '{3'b000, 5'h15, 5'h0a, 5'h1f, 5'h15}, '{3'b001, 5'h15, 5'h0a, 5'h1f, 5'h15},
      '{3'b110, 5'h15, 5'h0a, 5'h11, 5'h0a}, '{3'b101, 5'h15, 5'h0a, 5'h11, 5'h11},
      '{3'b111, 5'h0c, 5'h0a, 5'h02, 5'h02}, '{3'b100, 5'h0c, 5'h0a, 5'h02, 5'h0c}};
   initial begin
      forever #10 clk = ~clk;
   end
   dsg_bus_master i_dsg_bus_master (.clk(clk), .start(start), .wr(wr), .addr(addr),
      .wdata(wdata), .done(done), .rdata(rdata), .resp(resp), .avs_address(av_a),
      .avs_read(av_r), .avs_write(av_w), .avs_writedata(av_wd), .avs_readdata(av_rd),
      .avs_waitrequest(av_wait), .avs_response(av_resp));
   dsg_clock_reset_ctl i_dsg_clock_reset_ctl (.clk(clk), .reset(reset), .avs_address(av_a),
      .avs_read(av_r), .avs_write(av_w), .avs_writedata(av_wd), .avs_readdata(av_rd),
      .avs_waitrequest(av_wait), .avs_response(av_resp), .run_port_gate_reg(run),
      .sleep_port_gate_reg(slp), .mode(mode), .capability_reg_one(cap),
      .port_access_req(req), .port_clk_en(clk_en), .port_bus_fault(fault),
      .watchdog_reset_ctl(wdog), .irq(irq));
   task automatic give_verdict();
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      start <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      start <= 1'b0;
      do @(posedge clk); while (done !== 1'b1);
      #1;
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
      bus(1'b0, a, '0);
      chk(name, exp, rdata);
      chk("response", {30'h0, RESP_OKAY}, {30'h0, resp});
   endtask : rd
   task automatic poke(input logic [4:0] r);
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= '0;
      #1;
   endtask : poke
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(OFF_DEEP_GATE_2, 32'h0, "deep gate reset");
      rd(OFF_SOFT_RESET_0, 32'h0, "soft reset reset");
      chk("clk_en reset", 32'h0, {27'h0, clk_en});
      foreach (rows[i]) begin
         bus(1'b1, OFF_DEEP_GATE_2, {27'h0, rows[i].deep});
         @(posedge clk);
         mode <= rows[i].m;
         run <= rows[i].run;
         slp <= rows[i].slp;
         repeat (2) @(posedge clk);
         #1;
         chk("clk_en", {27'h0, rows[i].exp}, {27'h0, clk_en});
      end
      bus(1'b1, OFF_DEEP_GATE_2, 32'hffff_ffff);
      rd(OFF_DEEP_GATE_2, 32'h0000_001f, "deep gate ones");
      bus(1'b1, OFF_DEEP_GATE_2, {rdata[31:5], 5'h00});
      bus(1'b1, OFF_SOFT_RESET_0, 32'hffff_ffff);
      rd(OFF_SOFT_RESET_0, 32'h0000_0008, "soft reset ones");
      chk("wdog held", 32'h1, {31'h0, wdog});
      bus(1'b1, OFF_SOFT_RESET_0, 32'h0);
      chk("wdog released", 32'h0, {31'h0, wdog});
      @(posedge clk);
      cap <= 32'hffff_fff7;
      bus(1'b1, OFF_SOFT_RESET_0, 32'h0000_0008);
      rd(OFF_SOFT_RESET_0, 32'h0, "masked write");
      bus(1'b0, 12'h300, '0);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk("unmapped data", 32'h0, rdata);
      @(posedge clk);
      mode <= '0;
      run <= 5'h01;
      bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_001f);
      rd(OFF_IRQ_ENABLE, 32'h0000_001f, "irq enable");
      poke(5'h05);
      chk("fault", 32'h4, {27'h0, fault});
      rd(OFF_IRQ_STATUS, 32'h0000_0004, "status");
      chk("irq set", 32'h1, {31'h0, irq});
      bus(1'b1, OFF_IRQ_CLEAR, 32'h0000_0004);
      repeat (2) @(posedge clk);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(OFF_IRQ_CLEAR, 32'h0, "clear reads zero");
      bus(1'b1, OFF_IRQ_ENABLE, 32'h0);
      poke(5'h10);
      chk("fault e", 32'h10, {27'h0, fault});
      rd(OFF_IRQ_STATUS, 32'h0000_0010, "status e");
      chk("irq masked", 32'h0, {31'h0, irq});
      @(posedge clk);
      cap <= 32'h0000_0008;
      bus(1'b1, OFF_SOFT_RESET_0, 32'h0000_0008);
      chk("wdog set again", 32'h1, {31'h0, wdog});
      bus(1'b1, OFF_DEEP_GATE_2, 32'h0000_001f);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk("clk_en mid reset", 32'h0, {27'h0, clk_en});
      chk("wdog mid reset", 32'h0, {31'h0, wdog});
      rd(OFF_DEEP_GATE_2, 32'h0, "deep gate mid reset");
      rd(OFF_IRQ_STATUS, 32'h0, "status mid reset");
      give_verdict();
   end
endmodule : test_dsg_clock_reset_ctl
